// ### design/exec_pkg.sv
// shared constants and types for the or, stack, nop and multiply execute block
package exec_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   localparam logic [11:0] SP_HI_OFS   = 12'hffe;
   localparam logic [11:0] SP_LO_OFS   = 12'hfff;
   localparam logic [11:0] RP_OFS      = 12'hffd;
   localparam logic [11:0] FLAGS_OFS   = 12'hffc;
   localparam logic [11:0] SP_RESET    = 12'h000;
   localparam logic [7:0]  RP_RESET    = 8'h00;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;

   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;

   localparam logic [3:0] ESC_NIB  = 4'he;
   localparam logic [7:0] ESC_BYTE = 8'hee;

   localparam logic [7:0] OPC_NOP    = 8'h0f;
   localparam logic [7:0] OPC_OR_RR  = 8'h42;
   localparam logic [7:0] OPC_OR_RI  = 8'h43;
   localparam logic [7:0] OPC_OR_DD  = 8'h44;
   localparam logic [7:0] OPC_OR_DI  = 8'h45;
   localparam logic [7:0] OPC_OR_IMD = 8'h46;
   localparam logic [7:0] OPC_OR_IMI = 8'h47;
   localparam logic [7:0] OPC_ORX    = 8'h48;
   localparam logic [7:0] OPC_ORX_IM = 8'h49;
   localparam logic [7:0] OPC_POP_D  = 8'h50;
   localparam logic [7:0] OPC_POP_I  = 8'h51;
   localparam logic [7:0] OPC_POP_EXTENDED_ADDRESS   = 8'hd8;
   localparam logic [7:0] OPC_UNSIGNED_MULTIPLY   = 8'hf4;
   localparam logic [7:0] OPC_PUSH_D = 8'h70;
   localparam logic [7:0] OPC_PUSH_I = 8'h71;

   typedef enum logic [3:0] {
      S_OPC  = 4'h0,
      S_OPND = 4'h1,
      S_DEC  = 4'h2,
      S_PTRS = 4'h3,
      S_PTRD = 4'h4,
      S_RDS  = 4'h5,
      S_RDD  = 4'h6,
      S_RDL  = 4'h7,
      S_WR   = 4'h8,
      S_WRL  = 4'h9
   } state_t;

   typedef enum logic [2:0] {
      OP_NOP  = 3'h0,
      OP_OR   = 3'h1,
      OP_POP  = 3'h2,
      OP_PUSH = 3'h3,
      OP_UNSIGNED_MULTIPLY = 3'h4,
      OP_BAD  = 3'h5
   } op_t;

   typedef enum logic [1:0] {
      AM_WORK4 = 2'h0,
      AM_R8    = 2'h1,
      AM_EXT   = 2'h2
   } amode_t;

   typedef struct packed {
      state_t           st;
      logic             ph;
      op_t              op;
      logic [7:0]       opc;
      logic [1:0]       cnt;
      logic [1:0]       need;
      logic [2:0][7:0]  ob;
      logic [11:0]      src_a;
      logic [11:0]      dst_a;
      logic [11:0]      iss_addr;
      logic [11:0]      bus_q;
      logic [7:0]       src_v;
      logic [7:0]       dst_v;
      logic [7:0]       lo_v;
      logic             ind_s;
      logic             ind_d;
      logic             imm;
      logic [11:0]      sp;
      logic [7:0]       rp;
      logic [7:0]       fl;
      logic             done;
      logic             illegal;
   } exec_t;
endpackage

// ### design/reg_mem.sv
// register file storage, one port, registered read data
`timescale 1ns/1ps
module reg_mem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [DW-1:0] i_wdata,
   output logic      [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [2**AW];

   // read-before-write: a write never shows on the same cycle's read
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule // reg_mem

// ### design/operand_resolve.sv
// turns a raw operand address into a full 12-bit register file address
`timescale 1ns/1ps
module operand_resolve
   import exec_pkg::*;
(
   input  wire logic [11:0] i_raw,
   input  wire amode_t      i_mode,
   input  wire logic [7:0]  i_rp,
   output logic      [11:0] o_addr
);
   logic [11:0] work;

   // working register: page nibble, group nibble, low nibble
   assign work = {i_rp[3:0], i_rp[7:4], i_raw[3:0]};

   // escaped ranges never reach E0-EF or EE0-EEF directly
   always_comb begin
      case (i_mode)
         AM_WORK4: o_addr = work;
         AM_R8:    o_addr = (i_raw[7:4] == ESC_NIB) ? work : {4'h0, i_raw[7:0]};
         AM_EXT:   o_addr = (i_raw[11:4] == ESC_BYTE) ? work : i_raw;
         default:  o_addr = i_raw;
      endcase
   end
endmodule // operand_resolve

// ### design/logic_or_stack_nop_exec.sv
// execute unit for or, extended or, pop, push, nop and unsigned multiply
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module logic_or_stack_nop_exec
   import exec_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_byte,
   input  wire logic        i_byte_valid,
   output logic             o_byte_ready,
   output logic             o_done,
   output logic             o_illegal,
   output logic [7:0]       o_flags,
   output logic [11:0]      o_sp,
   input  wire logic [11:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [7:0]       o_rdata
);
   exec_t       s_reg;
   exec_t       s_next;
   logic [7:0]  mem_rdata;
   logic        mem_we;
   logic [11:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic [11:0] src_raw;
   logic [11:0] dst_raw;
   amode_t      src_mode;
   amode_t      dst_mode;
   logic [11:0] src_res;
   logic [11:0] dst_res;
   op_t         dop;
   logic        d_ind_s;
   logic        d_ind_d;
   logic        d_imm;
   logic [7:0]  imm_v;
   logic [15:0] prod;
   logic [7:0]  or_res;
   logic [7:0]  rd_val;
   logic        bus_sel;
   logic [11:0] rd_a;
   logic [7:0]  wv;
   logic [11:0] wa;

   function automatic logic is_special(input logic [11:0] a);
      return (a == SP_HI_OFS) || (a == SP_LO_OFS) || (a == RP_OFS) || (a == FLAGS_OFS);
   endfunction

   function automatic logic [7:0] special_read(input logic [11:0] a, input exec_t s);
      case (a)
         SP_HI_OFS: return {4'h0, s.sp[11:8]};
         SP_LO_OFS: return s.sp[7:0];
         RP_OFS:    return s.rp;
         FLAGS_OFS: return s.fl;
         default:   return 8'h00;
      endcase
   endfunction

   function automatic exec_t special_write(input logic [11:0] a, input logic [7:0] d,
                                           input exec_t s);
      exec_t r;
      r = s;
      case (a)
         SP_HI_OFS: r.sp[11:8] = d[3:0];
         SP_LO_OFS: r.sp[7:0]  = d;
         RP_OFS:    r.rp       = d;
         FLAGS_OFS: r.fl       = d;
         default:   r.sp       = s.sp;
      endcase
      return r;
   endfunction

   function automatic logic [1:0] opnd_count(input logic [7:0] opc);
      case (opc)
         OPC_OR_RR, OPC_OR_RI, OPC_POP_D, OPC_POP_I, OPC_UNSIGNED_MULTIPLY,
         OPC_PUSH_D, OPC_PUSH_I:                         return 2'h1;
         OPC_OR_DD, OPC_OR_DI, OPC_OR_IMD, OPC_OR_IMI,
         OPC_POP_EXTENDED_ADDRESS:                                       return 2'h2;
         OPC_ORX, OPC_ORX_IM:                            return 2'h3;
         default:                                        return 2'h0;
      endcase
   endfunction

   function automatic state_t first_read(input op_t op, input logic imm);
      if (op == OP_UNSIGNED_MULTIPLY || (op == OP_OR && imm)) begin
         return S_RDD;
      end
      return S_RDS;
   endfunction

   operand_resolve u_src (
      .i_raw  (src_raw),
      .i_mode (src_mode),
      .i_rp   (s_reg.rp),
      .o_addr (src_res)
   );

   operand_resolve u_dst (
      .i_raw  (dst_raw),
      .i_mode (dst_mode),
      .i_rp   (s_reg.rp),
      .o_addr (dst_res)
   );

   reg_mem #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_mem (
      .i_clk   (i_clk),
      .i_we    (mem_we),
      .i_addr  (mem_addr),
      .i_wdata (mem_wdata),
      .o_rdata (mem_rdata)
   );

   assign prod   = 16'(s_reg.dst_v) * 16'(s_reg.lo_v);
   assign or_res = s_reg.dst_v | s_reg.src_v;
   assign bus_sel = i_wr | i_rd;
   assign rd_val = is_special(s_reg.iss_addr) ? special_read(s_reg.iss_addr, s_reg) : mem_rdata;

   // operand field extraction per opcode
   always_comb begin
      src_raw  = 12'h000;
      dst_raw  = 12'h000;
      src_mode = AM_R8;
      dst_mode = AM_R8;
      dop      = OP_BAD;
      d_ind_s  = 1'b0;
      d_ind_d  = 1'b0;
      d_imm    = 1'b0;
      imm_v    = 8'h00;
      case (s_reg.opc)
         OPC_NOP: dop = OP_NOP;
         OPC_OR_RR, OPC_OR_RI: begin
            dop      = OP_OR;
            dst_raw  = {8'h00, s_reg.ob[0][7:4]};
            src_raw  = {8'h00, s_reg.ob[0][3:0]};
            dst_mode = AM_WORK4;
            src_mode = AM_WORK4;
            d_ind_s  = (s_reg.opc == OPC_OR_RI);
         end
         OPC_OR_DD, OPC_OR_DI: begin
            dop     = OP_OR;
            src_raw = {4'h0, s_reg.ob[0]};
            dst_raw = {4'h0, s_reg.ob[1]};
            d_ind_s = (s_reg.opc == OPC_OR_DI);
         end
         OPC_OR_IMD, OPC_OR_IMI: begin
            dop     = OP_OR;
            dst_raw = {4'h0, s_reg.ob[0]};
            imm_v   = s_reg.ob[1];
            d_imm   = 1'b1;
            d_ind_d = (s_reg.opc == OPC_OR_IMI);
         end
         OPC_ORX: begin
            dop      = OP_OR;
            src_raw  = {s_reg.ob[0], s_reg.ob[1][7:4]};
            dst_raw  = {s_reg.ob[1][3:0], s_reg.ob[2]};
            src_mode = AM_EXT;
            dst_mode = AM_EXT;
         end
         OPC_ORX_IM: begin
            dop      = OP_OR;
            imm_v    = s_reg.ob[0];
            d_imm    = 1'b1;
            dst_raw  = {s_reg.ob[1][3:0], s_reg.ob[2]};
            dst_mode = AM_EXT;
         end
         OPC_POP_D, OPC_POP_I: begin
            dop     = OP_POP;
            dst_raw = {4'h0, s_reg.ob[0]};
            d_ind_d = (s_reg.opc == OPC_POP_I);
         end
         OPC_POP_EXTENDED_ADDRESS: begin
            dop      = OP_POP;
            dst_raw  = {s_reg.ob[0], s_reg.ob[1][7:4]};
            dst_mode = AM_EXT;
         end
         OPC_PUSH_D, OPC_PUSH_I: begin
            dop     = OP_PUSH;
            src_raw = {4'h0, s_reg.ob[0]};
            d_ind_s = (s_reg.opc == OPC_PUSH_I);
         end
         OPC_UNSIGNED_MULTIPLY: begin
            dop     = OP_UNSIGNED_MULTIPLY;
            dst_raw = {4'h0, s_reg.ob[0]};
         end
         default: dop = OP_BAD;
      endcase
   end

   always_comb begin
      s_next         = s_reg;
      s_next.done    = 1'b0;
      s_next.illegal = 1'b0;
      mem_we         = 1'b0;
      mem_addr       = i_addr;
      mem_wdata      = i_wdata;
      rd_a           = s_reg.dst_a;
      wv             = 8'h00;
      wa             = s_reg.dst_a;
      // software access owns the port; the sequencer waits a cycle
      if (i_rd) begin
         s_next.bus_q = i_addr;
      end
      if (i_wr) begin
         if (is_special(i_addr)) begin
            s_next = special_write(i_addr, i_wdata, s_next);
         end else begin
            mem_we = 1'b1;
         end
      end
      case (s_reg.st)
         S_OPC: begin
            if (i_byte_valid) begin
               s_next.opc  = i_byte;
               s_next.cnt  = 2'h0;
               s_next.need = opnd_count(i_byte);
               s_next.st   = (opnd_count(i_byte) == 2'h0) ? S_DEC : S_OPND;
            end
         end
         S_OPND: begin
            if (i_byte_valid) begin
               s_next.ob[s_reg.cnt] = i_byte;
               s_next.cnt = s_reg.cnt + 2'h1;
               if (s_reg.cnt + 2'h1 == s_reg.need) begin
                  s_next.st = S_DEC;
               end
            end
         end
         S_DEC: begin
            s_next.op    = dop;
            s_next.ind_s = d_ind_s;
            s_next.ind_d = d_ind_d;
            s_next.imm   = d_imm;
            s_next.src_v = imm_v;
            s_next.src_a = (dop == OP_POP) ? s_reg.sp : src_res;
            s_next.dst_a = (dop == OP_PUSH) ? s_reg.sp - 12'h001 : dst_res;
            s_next.ph    = 1'b0;
            if (dop == OP_NOP || dop == OP_BAD) begin
               s_next.st      = S_OPC;
               s_next.done    = (dop == OP_NOP);
               s_next.illegal = (dop == OP_BAD);
            end else if (d_ind_s) begin
               s_next.st = S_PTRS;
            end else if (d_ind_d) begin
               s_next.st = S_PTRD;
            end else begin
               s_next.st = first_read(dop, d_imm);
            end
         end
         S_PTRS, S_PTRD, S_RDS, S_RDD, S_RDL: begin
            if (s_reg.st == S_PTRS || s_reg.st == S_RDS) begin
               rd_a = s_reg.src_a;
            end else if (s_reg.st == S_RDL) begin
               rd_a = s_reg.dst_a + 12'h001;
            end
            if (!s_reg.ph) begin
               if (!bus_sel) begin
                  mem_addr        = rd_a;
                  s_next.iss_addr = rd_a;
                  s_next.ph       = 1'b1;
               end
            end else begin
               s_next.ph = 1'b0;
               case (s_reg.st)
                  S_PTRS: begin
                     s_next.src_a = {4'h0, rd_val};
                     s_next.st = s_reg.ind_d ? S_PTRD : first_read(s_reg.op, s_reg.imm);
                  end
                  S_PTRD: begin
                     s_next.dst_a = {4'h0, rd_val};
                     s_next.st    = first_read(s_reg.op, s_reg.imm);
                  end
                  S_RDS: begin
                     s_next.src_v = rd_val;
                     s_next.st    = (s_reg.op == OP_OR) ? S_RDD : S_WR;
                  end
                  S_RDD: begin
                     s_next.dst_v = rd_val;
                     s_next.st    = (s_reg.op == OP_UNSIGNED_MULTIPLY) ? S_RDL : S_WR;
                  end
                  default: begin
                     s_next.lo_v = rd_val;
                     s_next.st   = S_WR;
                  end
               endcase
            end
         end
         S_WR, S_WRL: begin
            if (s_reg.st == S_WRL) begin
               wa = s_reg.dst_a + 12'h001;
               wv = prod[7:0];
            end else if (s_reg.op == OP_OR) begin
               wv = or_res;
            end else if (s_reg.op == OP_UNSIGNED_MULTIPLY) begin
               wv = prod[15:8];
            end else begin
               wv = s_reg.src_v;
            end
            if (!bus_sel) begin
               mem_addr  = wa;
               mem_wdata = wv;
               if (is_special(wa)) begin
                  s_next = special_write(wa, wv, s_next);
               end else begin
                  mem_we = 1'b1;
               end
               // only z, s and v move; c, d and h stay as they were
               if (s_reg.op == OP_OR) begin
                  s_next.fl[FLAG_Z] = (or_res == 8'h00);
                  s_next.fl[FLAG_S] = or_res[7];
                  s_next.fl[FLAG_V] = 1'b0;
               end
               if (s_reg.op == OP_POP) begin
                  s_next.sp = s_reg.sp + 12'h001;
               end else if (s_reg.op == OP_PUSH) begin
                  s_next.sp = s_reg.sp - 12'h001;
               end
               if (s_reg.op == OP_UNSIGNED_MULTIPLY && s_reg.st == S_WR) begin
                  s_next.st = S_WRL;
               end else begin
                  s_next.st   = S_OPC;
                  s_next.done = 1'b1;
               end
            end
         end
         default: s_next.st = S_OPC;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_reg    <= '0;
         s_reg.sp <= SP_RESET;
         s_reg.rp <= RP_RESET;
         s_reg.fl <= FLAGS_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_byte_ready = (s_reg.st == S_OPC) || (s_reg.st == S_OPND);
   assign o_done       = s_reg.done;
   assign o_illegal    = s_reg.illegal;
   assign o_flags      = s_reg.fl;
   assign o_sp         = s_reg.sp;
   assign o_rdata      = is_special(s_reg.bus_q) ? special_read(s_reg.bus_q, s_reg) : mem_rdata;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   or_zero_flag_a: assert property (o_done && s_reg.op == OP_OR |->
      o_flags[FLAG_Z] == ($past(or_res) == 8'h00) && o_flags[FLAG_S] == $past(or_res[7]))
      else $error("or zero or sign flag wrong");
   or_kept_flags_a: assert property (o_done && s_reg.op == OP_OR |->
      !o_flags[FLAG_V] && o_flags[FLAG_C] == $past(o_flags[FLAG_C])
      && o_flags[FLAG_D] == $past(o_flags[FLAG_D]) && o_flags[FLAG_H] == $past(o_flags[FLAG_H]))
      else $error("or touched c, d or h or left v set");
   pop_sp_inc_a: assert property (o_done && s_reg.op == OP_POP |->
      o_sp == $past(o_sp) + 12'h001) else $error("pop did not add one to sp");
   push_sp_dec_a: assert property (o_done && s_reg.op == OP_PUSH |->
      o_sp == $past(o_sp) - 12'h001) else $error("push did not take one from sp");
   push_store_a: assert property (s_reg.st == S_WR && s_reg.op == OP_PUSH && !bus_sel |->
      mem_addr == o_sp - 12'h001) else $error("push wrote away from sp minus one");
   unsigned_multiply_split_a: assert property (s_reg.st == S_WR && s_reg.op == OP_UNSIGNED_MULTIPLY && !bus_sel |->
      mem_wdata == prod[15:8] && mem_addr == s_reg.dst_a ##1 s_reg.st == S_WRL)
      else $error("multiply high byte misplaced");
   flags_still_a: assert property (o_done && s_reg.op inside {OP_POP, OP_UNSIGNED_MULTIPLY, OP_NOP} |->
      $stable(o_flags)) else $error("flags moved on pop, multiply or nop");
   nop_quiet_a: assert property (s_reg.st == S_DEC && dop == OP_NOP && !i_wr |=>
      $stable(o_sp) && $stable(o_flags) && o_done) else $error("nop changed state");
   esc_r8_a: assert property (s_reg.st == S_DEC && dst_mode == AM_R8
      && dst_raw[7:4] == ESC_NIB |-> dst_res == {s_reg.rp[3:0], s_reg.rp[7:4], dst_raw[3:0]})
      else $error("escaped byte address not a working register");
   esc_ext_a: assert property (s_reg.st == S_DEC && dst_mode == AM_EXT
      && dst_raw[11:4] == ESC_BYTE |-> dst_res == {s_reg.rp[3:0], s_reg.rp[7:4], dst_raw[3:0]})
      else $error("escaped 12-bit address not a working register");

   or_done_c:   cover property (o_done && s_reg.op == OP_OR);
   unsigned_multiply_done_c: cover property (o_done && s_reg.op == OP_UNSIGNED_MULTIPLY);
   pop_done_c:  cover property (o_done && s_reg.op == OP_POP);
   push_done_c: cover property (o_done && s_reg.op == OP_PUSH);
endmodule // logic_or_stack_nop_exec

// ### dv/tb_logic_or_stack_nop_exec.sv
// self-checking bench for the or, stack, nop and multiply execute unit
`timescale 1ns/1ps
module tb_logic_or_stack_nop_exec;
   import exec_pkg::*;
   logic        i_clk        = 1'b0;
   logic        i_rst_n      = 1'b0;
   logic [7:0]  i_byte       = 8'h00;
   logic        i_byte_valid = 1'b0;
   logic [11:0] i_addr       = 12'h000;
   logic [7:0]  i_wdata      = 8'h00;
   logic        i_wr         = 1'b0;
   logic        i_rd         = 1'b0;
   logic        o_byte_ready;
   logic        o_done;
   logic        o_illegal;
   logic [7:0]  o_flags;
   logic [11:0] o_sp;
   logic [7:0]  o_rdata;
   logic [7:0]  fl_exp;
   int          miscompares     = 0;
   int          samples_checked = 0;

   always #20 i_clk = ~i_clk;

   logic_or_stack_nop_exec dut_u (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_byte       (i_byte),
      .i_byte_valid (i_byte_valid),
      .o_byte_ready (o_byte_ready),
      .o_done       (o_done),
      .o_illegal    (o_illegal),
      .o_flags      (o_flags),
      .o_sp         (o_sp),
      .i_addr       (i_addr),
      .i_wdata      (i_wdata),
      .i_wr         (i_wr),
      .i_rd         (i_rd),
      .o_rdata      (o_rdata)
   );

   task automatic report_and_stop;
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // strobe dropped at the next edge, so back-to-back calls never double-drive it
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   // read data first stands in the cycle after the strobe
   task automatic rc(input logic [11:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      @(negedge i_clk);
      chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, o_rdata});
   endtask

   // bytes packed msb first, n of them; waits for the end pulse
   task automatic run(input logic [31:0] w, input int n, input logic ill);
      int k;
      for (int j = 0; j < n; j++) begin
         @(posedge i_clk);
         i_byte       <= w[31-8*j -: 8];
         i_byte_valid <= 1'b1;
         k = 0;
         do begin
            @(negedge i_clk);
            k++;
         end while (o_byte_ready !== 1'b1 && k < 50);
      end
      @(posedge i_clk);
      i_byte_valid <= 1'b0;
      k = 0;
      do begin
         @(negedge i_clk);
         k++;
      end while (o_done !== 1'b1 && o_illegal !== 1'b1 && k < 50);
      chk("end pulse", {10'h0, ~ill, ill}, {10'h0, o_done, o_illegal});
   endtask

   function automatic logic [7:0] or_fl(input logic [7:0] f, input logic [7:0] r);
      or_fl         = f;
      or_fl[FLAG_Z] = (r == 8'h00);
      or_fl[FLAG_S] = r[7];
      or_fl[FLAG_V] = 1'b0;
   endfunction

   task automatic orchk(input logic [11:0] a, input logic [7:0] r);
      fl_exp = or_fl(fl_exp, r);
      rc(a, r);
      chk("flags", {4'h0, fl_exp}, {4'h0, o_flags});
   endtask

   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      chk("sp after reset", SP_RESET, o_sp);
      chk("flags after reset", {4'h0, FLAGS_RESET}, {4'h0, o_flags});
      // v preset high so that its clearing is visible
      fl_exp = 8'h9f;
      wr(FLAGS_OFS, fl_exp);
      wr(RP_OFS, 8'h10);
      wr(12'h014, 8'h86);
      wr(12'h015, 8'h53);
      run(32'hf4e40000, 2, 1'b0);
      rc(12'h014, 8'h2b);
      rc(12'h015, 8'h72);
      chk("flags", {4'h0, fl_exp}, {4'h0, o_flags});
      run(32'h0f000000, 1, 1'b0);
      chk("flags", {4'h0, fl_exp}, {4'h0, o_flags});
      chk("sp", 12'h000, o_sp);
      rc(12'h015, 8'h72);
      wr(12'h011, 8'h38);
      wr(12'h01e, 8'h8d);
      run(32'h421e0000, 2, 1'b0);
      orchk(12'h011, 8'hbd);
      rc(12'h01e, 8'h8d);
      wr(12'h014, 8'hf9);
      wr(12'h01d, 8'h7b);
      wr(12'h07b, 8'h6a);
      run(32'h434d0000, 2, 1'b0);
      orchk(12'h014, 8'hfb);
      wr(12'h03a, 8'hf5);
      wr(12'h042, 8'h0a);
      run(32'h44423a00, 3, 1'b0);
      orchk(12'h03a, 8'hff);
      rc(12'h042, 8'h0a);
      wr(12'h015, 8'h70);
      wr(12'h045, 8'h3a);
      wr(12'h03a, 8'h7f);
      run(32'h4545e500, 3, 1'b0);
      orchk(12'h015, 8'h7f);
      wr(12'h07a, 8'h00);
      run(32'h467a0000, 3, 1'b0);
      orchk(12'h07a, 8'h00);
      wr(12'h013, 8'h3e);
      wr(12'h03e, 8'h0c);
      run(32'h47e30500, 3, 1'b0);
      orchk(12'h03e, 8'h0d);
      wr(12'h93a, 8'hf5);
      wr(12'h142, 8'h0a);
      run(32'h4814293a, 4, 1'b0);
      orchk(12'h93a, 8'hff);
      wr(12'hd7a, 8'h07);
      run(32'h49600d7a, 4, 1'b0);
      orchk(12'hd7a, 8'h67);
      // page e, group 1: the escaped operand lands at e13
      wr(RP_OFS, 8'h1e);
      wr(12'he13, 8'hc0);
      run(32'h49050ee3, 4, 1'b0);
      orchk(12'he13, 8'hc5);
      wr(RP_OFS, 8'he0);
      wr(12'h0e5, 8'h01);
      run(32'h46e58000, 3, 1'b0);
      orchk(12'h0e5, 8'h81);
      wr(SP_HI_OFS, 8'h00);
      wr(SP_LO_OFS, 8'h70);
      rc(SP_HI_OFS, 8'h00);
      rc(SP_LO_OFS, 8'h70);
      wr(12'h070, 8'h44);
      run(32'h50340000, 2, 1'b0);
      rc(12'h034, 8'h44);
      rc(12'h070, 8'h44);
      chk("sp", 12'h071, o_sp);
      wr(12'h0e6, 8'h22);
      wr(12'h071, 8'h55);
      run(32'h51e60000, 2, 1'b0);
      rc(12'h022, 8'h55);
      chk("sp", 12'h072, o_sp);
      wr(12'h072, 8'h99);
      run(32'hd8345000, 3, 1'b0);
      rc(12'h345, 8'h99);
      chk("sp", 12'h073, o_sp);
      chk("flags", {4'h0, fl_exp}, {4'h0, o_flags});
      wr(12'h0fc, 8'hab);
      run(32'h70fc0000, 2, 1'b0);
      chk("sp", 12'h072, o_sp);
      rc(12'h072, 8'hab);
      rc(SP_LO_OFS, 8'h72);
      // indirect push: escaped pointer register holds the source address
      wr(12'h0e4, 8'hfc);
      run(32'h71e40000, 2, 1'b0);
      chk("sp", 12'h071, o_sp);
      rc(12'h071, 8'hab);
      // pointer at the top of the space wraps both ways
      wr(SP_HI_OFS, 8'h0f);
      wr(SP_LO_OFS, 8'hff);
      run(32'h50200000, 2, 1'b0);
      chk("sp", 12'h000, o_sp);
      run(32'h70200000, 2, 1'b0);
      chk("sp", 12'hfff, o_sp);
      run(32'h00000000, 1, 1'b1);
      chk("sp", 12'hfff, o_sp);
      chk("flags", {4'h0, fl_exp}, {4'h0, o_flags});
      report_and_stop();
   end
endmodule // tb_logic_or_stack_nop_exec
